/* common/mft_pkg.sv */
// package: register map, field positions, encodings for the multifunction timer
package mft_pkg;
    // register indices on the plain register port
    localparam logic [3:0] ADDR_CNT1 = 4'h0;
    localparam logic [3:0] ADDR_RCA = 4'h1;
    localparam logic [3:0] ADDR_RCB = 4'h2;
    localparam logic [3:0] ADDR_CNT2 = 4'h3;
    localparam logic [3:0] ADDR_PRSC = 4'h4;
    localparam logic [3:0] ADDR_CSEL = 4'h5;
    localparam logic [3:0] ADDR_CTRL = 4'h6;
    // reset values and counter preset value
    localparam logic [7:0] PRSC_RST = 8'h00;
    localparam logic [7:0] CSEL_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] PRESET_VAL = 16'hFFFF;
    // field positions
    localparam int PRSC_MSB = 4;
    localparam int CS1_LSB = 0;
    localparam int CS2_LSB = 3;
    localparam int CTL_EN = 7;
    localparam int CTL_AOUT = 6;
    localparam int CTL_BEN = 5;
    localparam int CTL_AEN = 4;
    localparam int CTL_BPOL = 3;
    localparam int CTL_APOL = 2;
    // clock source codes
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_PRESC = 3'h1;
    localparam logic [2:0] SRC_EVENT = 3'h2;
    localparam logic [2:0] SRC_PACC = 3'h3;
    localparam logic [2:0] SRC_SLOW = 3'h4;
    // mode select codes
    localparam logic [1:0] MODE_PWM = 2'h0;
    localparam logic [1:0] MODE_DCAP = 2'h1;
    localparam logic [1:0] MODE_DUAL = 2'h2;
    localparam logic [1:0] MODE_SCAP = 2'h3;
endpackage

/* rtl/mft_timer.sv */
// design: multifunction timer control and datapath
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module mft_timer
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic i_slow_tick,
    input wire logic i_timer_pin_a,
    output logic o_timer_pin_a,
    output logic o_timer_pin_a_oe_n,
    input wire logic i_timer_pin_b,
    output logic o_cnt1_underflow,
    output logic o_cnt2_underflow
);
    typedef struct packed {
        logic [7:0] prsc;
        logic [7:0] csel;
        logic [7:0] ctrl;
        logic [15:0] cnt1;
        logic [15:0] cnt2;
        logic [15:0] rca;
        logic [15:0] rcb;
        logic [4:0] pcnt;
        logic [1:0] a_sync;
        logic [1:0] b_sync;
        logic a_last;
        logic b_last;
        logic [15:0] rdata;
        logic uf1;
        logic uf2;
    } mft_state_t;

    mft_state_t state_reg;
    mft_state_t state_next;

    // source gives a count enable for this cycle
    function automatic logic src_tick(input logic [2:0] src, input logic presc,
                                      input logic slow, input logic bev,
                                      input logic bgate, input logic ext_ok);
        unique case (src)
            mft_pkg::SRC_PRESC: src_tick = presc;
            mft_pkg::SRC_EVENT: src_tick = ext_ok & bev;
            mft_pkg::SRC_PACC: src_tick = ext_ok & bgate & presc;
            mft_pkg::SRC_SLOW: src_tick = slow;
            default: src_tick = 1'b0; // none and reserved codes stop
        endcase
    endfunction

    // polarity-selected edge on synchronised samples
    function automatic logic edge_hit(input logic cur, input logic last, input logic pol);
        edge_hit = pol ? (cur & ~last) : (~cur & last);
    endfunction

    logic en;
    logic [1:0] mode;
    logic presc_tick;
    logic a_ev;
    logic b_ev;
    logic b_gate;
    logic ext_ok;
    logic tick1;
    logic tick2;
    logic a_is_out;
    logic wr_ok;

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        state_next = state_reg;
        en = state_reg.ctrl[mft_pkg::CTL_EN];
        mode = state_reg.ctrl[1:0];
        ext_ok = (mode == mft_pkg::MODE_PWM) || (mode == mft_pkg::MODE_DUAL);
        wr_ok = i_wr & en;
        // pin sync and edge detect
        state_next.a_sync = {state_reg.a_sync[0], i_timer_pin_a};
        state_next.b_sync = {state_reg.b_sync[0], i_timer_pin_b};
        state_next.a_last = state_reg.a_sync[1];
        state_next.b_last = state_reg.b_sync[1];
        a_ev = edge_hit(state_reg.a_sync[1], state_reg.a_last,
                        state_reg.ctrl[mft_pkg::CTL_APOL]);
        b_ev = edge_hit(state_reg.b_sync[1], state_reg.b_last,
                        state_reg.ctrl[mft_pkg::CTL_BPOL]);
        b_gate = state_reg.b_sync[1] == state_reg.ctrl[mft_pkg::CTL_BPOL];
        // prescaler divides by field plus one
        presc_tick = state_reg.pcnt == state_reg.prsc[mft_pkg::PRSC_MSB:0];
        if (!en)
            state_next.pcnt = 5'h00;
        else if (presc_tick)
            state_next.pcnt = 5'h00;
        else
            state_next.pcnt = state_reg.pcnt + 5'h01;
        // counting starts once a source is written and the enable bit is set; event and gated prescaler sources count only in PWM or dual counter mode
        tick1 = en & src_tick(state_reg.csel[2:0], presc_tick, i_slow_tick,
                              b_ev, b_gate, ext_ok);
        tick2 = en & src_tick(state_reg.csel[5:3], presc_tick, i_slow_tick,
                              b_ev, b_gate, ext_ok);
        a_is_out = en & state_reg.ctrl[mft_pkg::CTL_AEN] & (mode != mft_pkg::MODE_DCAP);
        state_next.uf1 = 1'b0;
        state_next.uf2 = 1'b0;
        // counter one
        if (tick1)
        begin
            if (state_reg.cnt1 == 16'h0000)
            begin
                state_next.uf1 = 1'b1;
                if (mode != mft_pkg::MODE_DCAP)
                    state_next.cnt1 = state_reg.rca;
                else
                    state_next.cnt1 = mft_pkg::PRESET_VAL;
                if (a_is_out)
                    state_next.ctrl[mft_pkg::CTL_AOUT] =
                        ~state_reg.ctrl[mft_pkg::CTL_AOUT];
            end
            else
                state_next.cnt1 = state_reg.cnt1 - 16'h0001;
        end
        // counter two; dual counter mode reloads from B
        if (tick2)
        begin
            if (state_reg.cnt2 == 16'h0000)
            begin
                state_next.uf2 = 1'b1;
                state_next.cnt2 = (mode == mft_pkg::MODE_DUAL) ? state_reg.rcb
                                                                : mft_pkg::PRESET_VAL;
            end
            else
                state_next.cnt2 = state_reg.cnt2 - 16'h0001;
        end
        // captures: copy counter first, then optional preset
        if (en && mode == mft_pkg::MODE_DCAP)
        begin
            if (a_ev)
            begin
                state_next.rca = state_reg.cnt1;
                if (state_reg.ctrl[mft_pkg::CTL_AEN])
                    state_next.cnt1 = mft_pkg::PRESET_VAL;
            end
            if (b_ev)
            begin
                state_next.rcb = state_reg.cnt1;
                if (state_reg.ctrl[mft_pkg::CTL_BEN])
                    state_next.cnt1 = mft_pkg::PRESET_VAL;
            end
        end
        if (en && mode == mft_pkg::MODE_SCAP && b_ev)
        begin
            state_next.rcb = state_reg.cnt2;
            if (state_reg.ctrl[mft_pkg::CTL_BEN])
                state_next.cnt2 = mft_pkg::PRESET_VAL;
        end
        // software writes win over hardware updates
        if (i_wr)
        begin
            unique case (i_addr)
                mft_pkg::ADDR_PRSC: state_next.prsc = {3'h0, i_wdata[4:0]};
                mft_pkg::ADDR_CSEL: state_next.csel = {2'h0, i_wdata[5:0]};
                mft_pkg::ADDR_CTRL: state_next.ctrl = i_wdata[7:0];
                mft_pkg::ADDR_CNT1: if (wr_ok) state_next.cnt1 = i_wdata;
                mft_pkg::ADDR_CNT2: if (wr_ok) state_next.cnt2 = i_wdata;
                mft_pkg::ADDR_RCA: if (wr_ok) state_next.rca = i_wdata;
                mft_pkg::ADDR_RCB: if (wr_ok) state_next.rcb = i_wdata;
                default: ;
            endcase
        end
        // read data one cycle after strobe
        state_next.rdata = 16'h0000;
        if (i_rd)
        begin
            unique case (i_addr)
                mft_pkg::ADDR_PRSC: state_next.rdata = {8'h00, state_reg.prsc};
                mft_pkg::ADDR_CSEL: state_next.rdata = {8'h00, state_reg.csel};
                mft_pkg::ADDR_CTRL: state_next.rdata = {8'h00, state_reg.ctrl};
                mft_pkg::ADDR_CNT1: state_next.rdata = state_reg.cnt1;
                mft_pkg::ADDR_CNT2: state_next.rdata = state_reg.cnt2;
                mft_pkg::ADDR_RCA: state_next.rdata = state_reg.rca;
                mft_pkg::ADDR_RCB: state_next.rdata = state_reg.rcb;
                default: state_next.rdata = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; counters and reload registers keep value through reset
    always_ff @(posedge i_mclk)
    begin
        state_reg <= state_next;
        if (i_rst)
        begin
            state_reg.prsc <= mft_pkg::PRSC_RST;
            state_reg.csel <= mft_pkg::CSEL_RST;
            state_reg.ctrl <= mft_pkg::CTRL_RST;
            state_reg.pcnt <= 5'h00;
            state_reg.rdata <= 16'h0000;
            state_reg.uf1 <= 1'b0;
            state_reg.uf2 <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs; pin A drives when enabled with A enable set in any mode but dual capture, otherwise an input
    assign o_rdata = state_reg.rdata;
    assign o_timer_pin_a = state_reg.ctrl[mft_pkg::CTL_AOUT];
    assign o_timer_pin_a_oe_n = ~(state_reg.ctrl[mft_pkg::CTL_EN]
                                 & state_reg.ctrl[mft_pkg::CTL_AEN]
                                 & (state_reg.ctrl[1:0] != mft_pkg::MODE_DCAP));
    assign o_cnt1_underflow = state_reg.uf1;
    assign o_cnt2_underflow = state_reg.uf2;
endmodule // mft_timer

/* tb/mft_pins.sv */
// partner: outside levels on the two timer pins
`timescale 1ns/1ps
module mft_pins
(
    input wire logic i_a_out,
    input wire logic i_a_oe_n,
    input wire logic i_a_level,
    input wire logic i_b_level,
    output logic o_a_wire,
    output logic o_b_wire
);
    // pin A follows the timer while driven, else the outside level
    assign o_a_wire = i_a_oe_n ? i_a_level : i_a_out;
    assign o_b_wire = i_b_level;
endmodule // mft_pins

/* tb/mft_timer_asserts.sv */
// checker: port assertions for the timer
`timescale 1ns/1ps
module mft_timer_asserts
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic i_slow_tick,
    input wire logic i_timer_pin_a,
    input wire logic o_timer_pin_a,
    input wire logic o_timer_pin_a_oe_n,
    input wire logic i_timer_pin_b,
    input wire logic o_cnt1_underflow,
    input wire logic o_cnt2_underflow
);
    logic [7:0] ctl_reg;
    logic [7:0] sel_reg;
    // shadows of mode control and source select
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            ctl_reg <= 8'h00;
            sel_reg <= 8'h00;
        end
        else if (i_wr && i_addr == mft_pkg::ADDR_CTRL)
            ctl_reg <= i_wdata[7:0];
        else if (i_wr && i_addr == mft_pkg::ADDR_CSEL)
            sel_reg <= i_wdata[7:0];
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_rst_idle;
        $past(i_rst) |-> o_timer_pin_a_oe_n && !o_timer_pin_a;
    endproperty
    property p_oe;
        o_timer_pin_a_oe_n == !(ctl_reg[7] && ctl_reg[4] && ctl_reg[1:0] != 2'h1);
    endproperty
    property p_ctl_rd;
        $past(i_rd && i_addr == mft_pkg::ADDR_CTRL) |->
            o_rdata[15:7] == {8'h00, $past(ctl_reg[7])} && o_rdata[5:0] == $past(ctl_reg[5:0]);
    endproperty
    property p_sel_rd;
        $past(i_rd && i_addr == mft_pkg::ADDR_CSEL) |-> o_rdata[5:0] == $past(sel_reg[5:0]);
    endproperty
    property p_aout_wr;
        $past(i_wr && i_addr == mft_pkg::ADDR_CTRL) |-> o_timer_pin_a == $past(i_wdata[6]);
    endproperty
    property p_pin_hold;
        $changed(o_timer_pin_a) |-> $past(i_wr && i_addr == mft_pkg::ADDR_CTRL)
            || o_cnt1_underflow || $past(o_cnt1_underflow);
    endproperty
    property p_stop;
        (sel_reg[2:0] == 3'h0 && ctl_reg[1:0] != 2'h3)[*3] |-> !o_cnt1_underflow;
    endproperty
    property p_off;
        (!ctl_reg[7])[*3] |-> !o_cnt1_underflow && !o_cnt2_underflow;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("pin A not idle after reset");
    a_oe: assert property (p_oe) else $error("pin A drive enable wrong");
    a_ctl_rd: assert property (p_ctl_rd) else $error("mode control readback wrong");
    a_sel_rd: assert property (p_sel_rd) else $error("source select readback wrong");
    a_aout_wr: assert property (p_aout_wr) else $error("output state write lost");
    a_pin_hold: assert property (p_pin_hold) else $error("pin A moved without cause");
    a_stop: assert property (p_stop) else $error("stopped counter one underflowed");
    a_off: assert property (p_off) else $error("counting while disabled");
    c_uf1: cover property (o_cnt1_underflow);
    c_drive: cover property (!o_timer_pin_a_oe_n);
    c_cap: cover property ($past(i_rd && i_addr == mft_pkg::ADDR_RCB));
endmodule // mft_timer_asserts
bind mft_timer mft_timer_asserts i_mft_timer_asserts (.*);

/* tb/test_mft_timer.sv */
// testbench: register, prescale, event and capture scenarios
`timescale 1ns/1ps
`define CHK(g, e) \
begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
        miscompares++; \
        $display("ERROR %0t got %h exp %h", $time, g, e); \
    end \
end
module test_mft_timer;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_slow_tick = 1'b0;
    logic a_lvl = 1'b1;
    logic b_lvl = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic [15:0] o_rdata;
    logic i_timer_pin_a, i_timer_pin_b, o_timer_pin_a, o_timer_pin_a_oe_n;
    logic o_cnt1_underflow, o_cnt2_underflow;
    int miscompares = 0;
    int comparisons = 0;
    mft_timer i_mft_timer (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .i_slow_tick(i_slow_tick),
        .i_timer_pin_a(i_timer_pin_a),
        .o_timer_pin_a(o_timer_pin_a),
        .o_timer_pin_a_oe_n(o_timer_pin_a_oe_n),
        .i_timer_pin_b(i_timer_pin_b),
        .o_cnt1_underflow(o_cnt1_underflow),
        .o_cnt2_underflow(o_cnt2_underflow)
    );
    mft_pins i_mft_pins (.i_a_out(o_timer_pin_a), .i_a_oe_n(o_timer_pin_a_oe_n),
        .i_a_level(a_lvl), .i_b_level(b_lvl), .o_a_wire(i_timer_pin_a), .o_b_wire(i_timer_pin_b));
    // clock and watchdog
    initial
    begin
        forever #10 i_mclk = ~i_mclk;
    end
    initial
    begin
        repeat (20000) @(posedge i_mclk);
        miscompares++;
        print_verdict();
    end
    task automatic print_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // register bus cycles and underflow wait
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        `CHK(o_rdata, e)
    endtask
    task automatic wait_uf(output int n);
        n = 0;
        do
        begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        while (o_cnt1_underflow !== 1'b1 && n < 300);
    endtask
    // scenarios
    task automatic t_reset;
        rd_chk(mft_pkg::ADDR_PRSC, 16'h0000);
        rd_chk(mft_pkg::ADDR_CSEL, 16'h0000);
        rd_chk(mft_pkg::ADDR_CTRL, 16'h0000);
    endtask
    task automatic t_regs;
        wr_reg(mft_pkg::ADDR_CTRL, 16'h0080);
        wr_reg(mft_pkg::ADDR_CNT1, 16'h1234);
        wr_reg(mft_pkg::ADDR_RCA, 16'hA5A5);
        wr_reg(mft_pkg::ADDR_RCB, 16'h5A5A);
        wr_reg(mft_pkg::ADDR_CNT2, 16'h0F0F);
        wr_reg(mft_pkg::ADDR_PRSC, 16'h001F);
        rd_chk(mft_pkg::ADDR_PRSC, 16'h001F);
        rd_chk(mft_pkg::ADDR_RCB, 16'h5A5A);
        @(posedge i_mclk);
        i_rst <= 1'b1;
        @(posedge i_mclk);
        i_rst <= 1'b0;
        rd_chk(mft_pkg::ADDR_CNT2, 16'h0F0F);
        rd_chk(mft_pkg::ADDR_CTRL, 16'h0000);
        wr_reg(mft_pkg::ADDR_CNT1, 16'hFFEE);
        wr_reg(mft_pkg::ADDR_RCA, 16'h0000);
        rd_chk(mft_pkg::ADDR_CNT1, 16'h1234);
        rd_chk(mft_pkg::ADDR_RCA, 16'hA5A5);
    endtask
    task automatic t_div(input logic [15:0] p);
        int n;
        logic a0;
        wr_reg(mft_pkg::ADDR_CTRL, 16'h0090);
        wr_reg(mft_pkg::ADDR_RCA, 16'h0003);
        wr_reg(mft_pkg::ADDR_CNT1, 16'h0003);
        wr_reg(mft_pkg::ADDR_PRSC, p);
        wr_reg(mft_pkg::ADDR_CSEL, 16'h0001);
        wait_uf(n);
        a0 = o_timer_pin_a;
        wait_uf(n);
        `CHK(n, 4 * (p + 1))
        `CHK(o_timer_pin_a, !a0)
        wr_reg(mft_pkg::ADDR_CSEL, 16'h0000);
    endtask
    task automatic t_ev(input logic [15:0] c, input logic [15:0] e);
        b_lvl <= 1'b0;
        wr_reg(mft_pkg::ADDR_CTRL, c);
        wr_reg(mft_pkg::ADDR_CNT1, 16'h0010);
        wr_reg(mft_pkg::ADDR_CSEL, 16'h0002);
        repeat (3)
        begin
            b_lvl <= !b_lvl;
            repeat (4) @(posedge i_mclk);
        end
        rd_chk(mft_pkg::ADDR_CNT1, e);
    endtask
    task automatic t_slow;
        wr_reg(mft_pkg::ADDR_CTRL, 16'h0081);
        wr_reg(mft_pkg::ADDR_CNT2, 16'h0008);
        wr_reg(mft_pkg::ADDR_CSEL, 16'h0020);
        repeat (3)
        begin
            i_slow_tick <= 1'b1;
            @(posedge i_mclk);
            i_slow_tick <= 1'b0;
            repeat (2) @(posedge i_mclk);
        end
        rd_chk(mft_pkg::ADDR_CNT2, 16'h0005);
        // underflow of counter two reloads all ones outside dual counter mode
        wr_reg(mft_pkg::ADDR_CNT2, 16'h0000);
        @(posedge i_mclk);
        i_slow_tick <= 1'b1;
        @(posedge i_mclk);
        i_slow_tick <= 1'b0;
        #1;
        `CHK(o_cnt2_underflow, 1'b1)
        rd_chk(mft_pkg::ADDR_CNT2, 16'hFFFF);
    endtask
    task automatic t_cap;
        a_lvl <= 1'b1;
        b_lvl <= 1'b0;
        wr_reg(mft_pkg::ADDR_CSEL, 16'h0000);
        wr_reg(mft_pkg::ADDR_CTRL, 16'h00B9);
        wr_reg(mft_pkg::ADDR_CNT1, 16'h1234);
        b_lvl <= 1'b1;
        repeat (6) @(posedge i_mclk);
        rd_chk(mft_pkg::ADDR_RCB, 16'h1234);
        rd_chk(mft_pkg::ADDR_CNT1, 16'hFFFF);
        wr_reg(mft_pkg::ADDR_CNT1, 16'h0042);
        a_lvl <= 1'b0;
        repeat (6) @(posedge i_mclk);
        rd_chk(mft_pkg::ADDR_RCA, 16'h0042);
        rd_chk(mft_pkg::ADDR_CNT1, 16'hFFFF);
        rd_chk(mft_pkg::ADDR_CTRL, 16'h00B9);
    endtask
    // main sequence
    initial
    begin
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        t_reset();
        t_regs();
        t_div(16'h0000);
        t_div(16'h0002);
        t_div(16'h001F);
        t_ev(16'h0088, 16'h000E);
        t_ev(16'h0082, 16'h000F);
        t_ev(16'h008B, 16'h0010);
        t_slow();
        t_cap();
        print_verdict();
    end
endmodule // test_mft_timer
